// ==== hdl/sesc_host_ctrl.sv ====
// Overview of operation
// [R1] error flag only meaningful in correction modes
// [R2] class bit twelve picks multi or single
// [R3] no access while scrub active low
// [R4] pending low warns scrub soon; hold off
// [R5] reads corrected whenever correction enabled
// [R6] A9,A10 low with flag high writes configuration
// [R7] A9 high, A10 low reads configuration
// [R8] A7,A10 high reads counter on DQ[18:0]
// [R9] configuration write presets counter to ones
// [R10] scrub error located by reading counter
// [R11] never present reserved A7-A10 combinations
// [R12] bits three..zero set scrub rate
// [R13] bits seven..four set warning delay
// [R14] bypass bit eight disables correction, scrub
// [R15] bit eleven low enables scrubbing
// [R16] A10,A9 zero when programming; upper ignored
// [R17] write configuration first, read back after
// [R18] recommended initial configuration values
// [R19] correction covers each 32-bit word
// [R20] master drives pending low before scrub
// [R21] scrub active output in master role
// [R22] role pin picks master or slave
// [R23] scheduler times are programmable counts
`timescale 1ns/10ps
`default_nettype none
module sesc_host_ctrl #(
  parameter int ACCESS_CYCLES = sesc_pkg::ACCESS_CYC,
  parameter int FLAG_CYCLES = sesc_pkg::FLAG_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  output logic [sesc_pkg::ADDR_W-1:0] memAddr,
  input wire logic [sesc_pkg::DATA_W-1:0] dqIn,
  output logic [sesc_pkg::DATA_W-1:0] dqOut,
  output logic dqOe,
  output logic chipSelectLowN,
  output logic chipSelectHigh,
  output logic outputEnableN,
  output logic writeEnableN,
  input wire logic errorFlagIn,
  output logic errorFlagOut,
  output logic errorFlagOe,
  input wire logic scrubActiveN,
  input wire logic scrubPendingN
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT,
    S_SETUP,
    S_HOLD,
    S_FLAG_LOW,
    S_RELEASE
  } sesc_state_t;

  sesc_state_t state_q;
  sesc_pkg::sesc_op_t op_q;
  sesc_pkg::sesc_op_t opSel;
  logic startPulse;
  logic [sesc_pkg::CFG_W-1:0] cfgValue;
  logic [sesc_pkg::ADDR_W-1:0] dataAddr;
  logic [sesc_pkg::STAT_W-1:0] statusClr;
  logic [sesc_pkg::STAT_W-1:0] status;
  logic [31:0] result_q;
  logic [7:0] cnt_q;
  logic done_q;
  logic abort_q;
  logic flag_q;
  logic scrubErr_q;
  logic cfgValid_q;
  logic [sesc_pkg::CFG_W-1:0] cfgShadow_q;
  logic doneSet;
  logic abortSet;
  logic flagSet;
  logic scrubErrSet;
  logic isFunc;
  logic scrubHit;
  logic retry_q;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  sesc_wb_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbSel(wbSel),
    .wbAdr(wbAdr),
    .wbDatW(wbDatW),
    .wbDatR(wbDatR),
    .wbAck(wbAck),
    .status(status),
    .result(result_q),
    .startPulse(startPulse),
    .opSel(opSel),
    .cfgValue(cfgValue),
    .dataAddr(dataAddr),
    .statusClr(statusClr)
  );

  assign status = {cfgShadow_q[sesc_pkg::CFG_CLASS_BIT], cfgValid_q, scrubErr_q,
                   !scrubActiveN, !scrubPendingN, flag_q, abort_q, done_q,
                   state_q != S_IDLE};

  // ----------------------------------------------------------------
  // function select address for the current operation
  // ----------------------------------------------------------------
  function automatic logic [sesc_pkg::ADDR_W-1:0] sel_addr(
    input sesc_pkg::sesc_op_t op,
    input logic [sesc_pkg::CFG_W-1:0] cfg,
    input logic [sesc_pkg::ADDR_W-1:0] addr
  );
    logic [sesc_pkg::ADDR_W-1:0] a;
    a = 19'h00000;
    case (op)
      sesc_pkg::OP_CFG_WRITE: begin
        a[sesc_pkg::CFG_W-1:0] = cfg; // R12 R13 R14 R15 R2
        a[sesc_pkg::SEL_A9] = 1'b0; // R6 R16
        a[sesc_pkg::SEL_A10] = 1'b0; // R6 R16
      end
      sesc_pkg::OP_CFG_READ: begin
        a[sesc_pkg::SEL_A9] = 1'b1; // R7
      end
      sesc_pkg::OP_CNT_READ: begin
        a[sesc_pkg::SEL_A7] = 1'b1; // R8
        a[sesc_pkg::SEL_A10] = 1'b1; // R8
      end
      default: begin
        a = addr;
      end
    endcase
    return a; // R11
  endfunction : sel_addr

  assign isFunc = (op_q != sesc_pkg::OP_DATA_READ);
  // a scrub starting during S_SETUP voids the access
  assign scrubHit = !scrubActiveN; // R3

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      op_q <= sesc_pkg::OP_CFG_WRITE;
      cnt_q <= 8'h00;
      memAddr <= 19'h00000;
      dqOut <= 32'h0000_0000;
      dqOe <= 1'b0;
      chipSelectLowN <= 1'b1;
      chipSelectHigh <= 1'b0;
      outputEnableN <= 1'b1;
      writeEnableN <= 1'b1;
      errorFlagOut <= 1'b0;
      errorFlagOe <= 1'b0;
      retry_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (startPulse) begin
            op_q <= opSel;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (scrubActiveN && scrubPendingN) begin // R3 R4
            memAddr <= sel_addr(op_q, cfgValue, dataAddr);
            chipSelectLowN <= 1'b0;
            chipSelectHigh <= 1'b1;
            writeEnableN <= 1'b1;
            outputEnableN <= isFunc;
            errorFlagOut <= 1'b1; // R6 R7
            errorFlagOe <= isFunc;
            cnt_q <= 8'(isFunc ? FLAG_CYCLES : ACCESS_CYCLES);
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (scrubHit) begin
            // remember the abort so the release goes back to waiting
            retry_q <= 1'b1; // R3
            state_q <= S_RELEASE;
          end else if (cnt_q <= 8'h01) begin
            state_q <= isFunc ? S_FLAG_LOW : S_RELEASE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_FLAG_LOW: begin
          errorFlagOut <= 1'b0;
          state_q <= S_HOLD;
        end
        S_HOLD: begin
          state_q <= S_RELEASE;
        end
        default: begin
          chipSelectLowN <= 1'b1;
          chipSelectHigh <= 1'b0;
          outputEnableN <= 1'b1;
          errorFlagOe <= 1'b0;
          errorFlagOut <= 1'b0;
          retry_q <= 1'b0;
          state_q <= retry_q ? S_WAIT : S_IDLE; // R3
        end
      endcase
    end
  end

  assign abortSet = (state_q == S_SETUP) && scrubHit;
  assign doneSet = (state_q == S_RELEASE) && !retry_q;
  // flag status is only set on data reads with correction on
  assign flagSet = (state_q == S_SETUP) && !isFunc && !scrubHit && (cnt_q <= 8'h01)
                   && errorFlagIn && cfgValid_q
                   && !cfgShadow_q[sesc_pkg::CFG_BYPASS_BIT]; // R1 R5 R14
  assign scrubErrSet = !scrubActiveN && !errorFlagOe && errorFlagIn && cfgValid_q
                       && !cfgShadow_q[sesc_pkg::CFG_BYPASS_BIT]; // R1 R10

  // ----------------------------------------------------------------
  // read data capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_q <= 32'h0000_0000;
    end else if (state_q == S_SETUP && !scrubHit && cnt_q <= 8'h01) begin
      case (op_q)
        sesc_pkg::OP_CFG_READ: begin
          result_q <= {19'h00000, dqIn[sesc_pkg::CFG_W-1:0]}; // R7 R17
        end
        sesc_pkg::OP_CNT_READ: begin
          result_q <= {13'h0000, dqIn[sesc_pkg::CNT_W-1:0]}; // R8 R10
        end
        sesc_pkg::OP_DATA_READ: begin
          result_q <= dqIn; // R5 R19
        end
        default: begin
          result_q <= result_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
      flag_q <= 1'b0;
      scrubErr_q <= 1'b0;
    end else begin
      done_q <= doneSet || (done_q && !statusClr[sesc_pkg::ST_DONE]);
      abort_q <= abortSet || (abort_q && !statusClr[sesc_pkg::ST_ABORT]);
      flag_q <= flagSet || (flag_q && !statusClr[sesc_pkg::ST_FLAG]);
      scrubErr_q <= scrubErrSet || (scrubErr_q && !statusClr[sesc_pkg::ST_SCRUB_ERR]);
    end
  end

  // ----------------------------------------------------------------
  // shadow of the last configuration written to the device
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgValid_q <= 1'b0;
      cfgShadow_q <= sesc_pkg::CFG_RESET;
    end else if (doneSet && op_q == sesc_pkg::OP_CFG_WRITE) begin
      cfgValid_q <= 1'b1; // R17 R9
      cfgShadow_q <= memAddr[sesc_pkg::CFG_W-1:0];
    end
  end

endmodule : sesc_host_ctrl
`default_nettype wire

// ==== common/sesc_pkg.sv ====
package sesc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 19;
  localparam int CFG_W = 13;
  localparam int CNT_W = 19;
  localparam int STAT_W = 9;

  // ----------------------------------------------------------------
  // controller register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_ADDR = 8'h10;

  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;

  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_FLAG = 3;
  localparam int ST_PENDING = 4;
  localparam int ST_SCRUB = 5;
  localparam int ST_SCRUB_ERR = 6;
  localparam int ST_CFG_VALID = 7;
  localparam int ST_CLASS = 8;

  // ----------------------------------------------------------------
  // device configuration word, carried on address lines
  // ----------------------------------------------------------------
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_DELAY_LSB = 4;
  localparam int SEL_A7 = 7;
  localparam int CFG_BYPASS_BIT = 8;
  localparam int SEL_A9 = 9;
  localparam int SEL_A10 = 10;
  localparam int CFG_SCRUB_OFF_BIT = 11;
  localparam int CFG_CLASS_BIT = 12;
  // rate code 7, delay code 10, correction on, scrub on, multi-bit class
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h00a7;

  typedef enum logic [1:0] {
    OP_CFG_WRITE,
    OP_CFG_READ,
    OP_CNT_READ,
    OP_DATA_READ
  } sesc_op_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 40000;
  localparam int FLAG_HOLD_PS = 12800;
  localparam int ACCESS_PS = 20000;

  function automatic int cycles_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cycles_up

  localparam int FLAG_HOLD_CYC = cycles_up(FLAG_HOLD_PS);
  localparam int ACCESS_CYC = cycles_up(ACCESS_PS);

endpackage : sesc_pkg

// ==== hdl/sesc_wb_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module sesc_wb_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic [sesc_pkg::STAT_W-1:0] status,
  input wire logic [31:0] result,
  output logic startPulse,
  output sesc_pkg::sesc_op_t opSel,
  output logic [sesc_pkg::CFG_W-1:0] cfgValue,
  output logic [sesc_pkg::ADDR_W-1:0] dataAddr,
  output logic [sesc_pkg::STAT_W-1:0] statusClr
);

  logic ack_q;
  logic take;
  logic [31:0] rd_d;

  assign take = wbCyc && wbStb && !ack_q;
  assign wbAck = ack_q;

  // ----------------------------------------------------------------
  // bus handshake and read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    if (wbAdr == sesc_pkg::REG_CFG) begin
      rd_d[sesc_pkg::CFG_W-1:0] = cfgValue;
    end else if (wbAdr == sesc_pkg::REG_STATUS) begin
      rd_d[sesc_pkg::STAT_W-1:0] = status;
    end else if (wbAdr == sesc_pkg::REG_RESULT) begin
      rd_d = result;
    end else if (wbAdr == sesc_pkg::REG_ADDR) begin
      rd_d[sesc_pkg::ADDR_W-1:0] = dataAddr;
    end else if (wbAdr == sesc_pkg::REG_CTRL) begin
      rd_d[sesc_pkg::CTRL_OP_LSB +: 2] = opSel;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      wbDatR <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      if (take && !wbWe) begin
        wbDatR <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgValue <= sesc_pkg::CFG_RESET; // R18
      dataAddr <= 19'h00000;
      opSel <= sesc_pkg::OP_CFG_WRITE;
      startPulse <= 1'b0;
      statusClr <= 9'h000;
    end else begin
      startPulse <= 1'b0;
      statusClr <= 9'h000;
      if (take && wbWe) begin
        if (wbAdr == sesc_pkg::REG_CTRL) begin
          if (wbSel[0]) begin
            opSel <= sesc_pkg::sesc_op_t'(wbDatW[sesc_pkg::CTRL_OP_LSB +: 2]);
            startPulse <= wbDatW[sesc_pkg::CTRL_GO_BIT];
          end
        end else if (wbAdr == sesc_pkg::REG_CFG) begin
          if (wbSel[0]) begin
            cfgValue[7:0] <= wbDatW[7:0];
          end
          if (wbSel[1]) begin
            cfgValue[12:8] <= wbDatW[12:8];
          end
        end else if (wbAdr == sesc_pkg::REG_ADDR) begin
          if (wbSel[0]) begin
            dataAddr[7:0] <= wbDatW[7:0];
          end
          if (wbSel[1]) begin
            dataAddr[15:8] <= wbDatW[15:8];
          end
          if (wbSel[2]) begin
            dataAddr[18:16] <= wbDatW[18:16];
          end
        end else if (wbAdr == sesc_pkg::REG_STATUS) begin
          if (wbSel[0]) begin
            statusClr <= wbDatW[sesc_pkg::STAT_W-1:0];
          end
        end
      end
    end
  end

endmodule : sesc_wb_regs
`default_nettype wire

// ==== bench/sesc_host_ctrl_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module sesc_host_ctrl_assertions #(
  parameter int ACCESS_CYCLES = sesc_pkg::ACCESS_CYC,
  parameter int FLAG_CYCLES = sesc_pkg::FLAG_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic [sesc_pkg::ADDR_W-1:0] memAddr,
  input wire logic dqOe,
  input wire logic chipSelectLowN,
  input wire logic chipSelectHigh,
  input wire logic outputEnableN,
  input wire logic writeEnableN,
  input wire logic errorFlagOut,
  input wire logic errorFlagOe,
  input wire logic scrubActiveN,
  input wire logic scrubPendingN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack;
    wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_start;
    $fell(chipSelectLowN) |-> $past(scrubActiveN) && $past(scrubPendingN);
  endproperty
  a_start: assert property (p_start) else $error("select while scrub near");
  property p_release;
    $fell(chipSelectLowN) |-> ##[1:8] chipSelectLowN;
  endproperty
  a_release: assert property (p_release) else $error("select held too long");
  property p_fsel;
    errorFlagOe |-> !chipSelectLowN && chipSelectHigh && outputEnableN && writeEnableN;
  endproperty
  a_fsel: assert property (p_fsel) else $error("bad function select");
  property p_reserved;
    errorFlagOe |-> !memAddr[10] || memAddr[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved select");
  property p_flag;
    $rose(errorFlagOe) |-> errorFlagOut ##[1:4] (errorFlagOe && !errorFlagOut);
  endproperty
  a_flag: assert property (p_flag) else $error("flag not high then low");
  property p_read;
    !outputEnableN |-> !chipSelectLowN && chipSelectHigh && !errorFlagOe && !dqOe;
  endproperty
  a_read: assert property (p_read) else $error("bad data read pins");
  property p_addr;
    !chipSelectLowN && !$past(chipSelectLowN) |-> $stable(memAddr);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
endmodule : sesc_host_ctrl_assertions
bind sesc_host_ctrl sesc_host_ctrl_assertions #(
  .ACCESS_CYCLES(ACCESS_CYCLES),
  .FLAG_CYCLES(FLAG_CYCLES)
) u_chk (
  .clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
  .memAddr(memAddr), .dqOe(dqOe), .chipSelectLowN(chipSelectLowN),
  .chipSelectHigh(chipSelectHigh), .outputEnableN(outputEnableN),
  .writeEnableN(writeEnableN), .errorFlagOut(errorFlagOut), .errorFlagOe(errorFlagOe),
  .scrubActiveN(scrubActiveN), .scrubPendingN(scrubPendingN)
);
`default_nettype wire

// ==== bench/sesc_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sesc_dev_model (
  input wire logic clk,
  input wire logic [18:0] addr,
  input wire logic csLowN,
  input wire logic csHigh,
  input wire logic oeN,
  input wire logic weN,
  input wire logic flagPin,
  input wire logic scrubReq,
  input wire logic [1:0] errInj,
  output logic [31:0] dq,
  output logic devFlag,
  output logic devFlagOe,
  output logic scrubActiveN,
  output logic scrubPendingN
);
  logic [12:0] cfgQ;
  logic [18:0] cntQ;
  logic [31:0] lastQ = 32'h0;
  logic flagPrevQ = 1'b0;
  logic [1:0] stQ = 2'h0;
  logic [3:0] tmrQ = 4'h0;
  logic fnSel;
  logic drv;
  assign fnSel = !csLowN && csHigh && oeN && weN && flagPin;
  always_comb begin
    drv = 1'b1;
    if (fnSel && addr[9] && !addr[10]) dq = {19'h0, cfgQ};
    else if (fnSel && addr[7] && addr[10]) dq = {13'h0, cntQ};
    else if (!csLowN && csHigh && !oeN) dq = {13'h0, addr} ^ 32'h5a5a0000;
    else begin
      // released bus shows inverse of last value
      drv = 1'b0;
      dq = ~lastQ;
    end
  end
  assign devFlagOe = (!csLowN && csHigh && !oeN) || !scrubActiveN;
  assign devFlag = !cfgQ[8] && (cfgQ[12] ? errInj[0] : errInj[1]);
  // master role only
  assign scrubPendingN = stQ == 2'h0;
  assign scrubActiveN = stQ != 2'h2;
  always @(posedge clk) begin
    flagPrevQ <= flagPin;
    if (drv) lastQ <= dq;
    if (stQ == 2'h0 && scrubReq && !cfgQ[8] && !cfgQ[11]) begin
      stQ <= 2'h1;
      tmrQ <= cfgQ[7:4];
    end else if (stQ == 2'h1 && tmrQ == 4'h0) begin
      stQ <= 2'h2;
      tmrQ <= 4'h3;
      cntQ <= cntQ + 19'h1;
    end else if (stQ != 2'h0 && tmrQ == 4'h0) stQ <= 2'h0;
    else if (stQ != 2'h0) tmrQ <= tmrQ - 4'h1;
    if (flagPrevQ && !flagPin && !csLowN && csHigh && oeN && !addr[9] && !addr[10]) begin
      cfgQ <= addr[12:0];
      cntQ <= '1;
    end
  end
endmodule : sesc_dev_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {logic [31:0] e; logic [31:0] m; string nm;} sesc_note_t;
  logic clk, rst_n, wbCyc, wbStb, wbWe, wbAck, dqOe, csLowN, csHigh, oeN, weN, f;
  logic flagOut, flagOe, devFlag, devFlagOe, scrubActiveN, scrubPendingN, scrubReq, flagPin;
  logic [3:0] wbSel;
  logic [7:0] wbAdr;
  logic [31:0] wbDatW, wbDatR, dqIn, dqOut, q;
  logic [18:0] memAddr, a;
  logic [1:0] errInj;
  logic [15:0] lf;
  logic [12:0] cv;
  int err_total, checks;
  sesc_note_t nq[$];
  always #20 clk = ~clk;
  assign flagPin = flagOe ? flagOut : devFlagOe ? devFlag : 1'b0;
  sesc_host_ctrl u_dut (
    .clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel),
    .wbAdr(wbAdr), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .memAddr(memAddr),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .chipSelectLowN(csLowN),
    .chipSelectHigh(csHigh), .outputEnableN(oeN), .writeEnableN(weN),
    .errorFlagIn(flagPin), .errorFlagOut(flagOut), .errorFlagOe(flagOe),
    .scrubActiveN(scrubActiveN), .scrubPendingN(scrubPendingN));
  sesc_dev_model u_dev (
    .clk(clk), .addr(memAddr), .csLowN(csLowN), .csHigh(csHigh), .oeN(oeN), .weN(weN),
    .flagPin(flagPin), .scrubReq(scrubReq), .errInj(errInj), .dq(dqIn), .devFlag(devFlag),
    .devFlagOe(devFlagOe), .scrubActiveN(scrubActiveN), .scrubPendingN(scrubPendingN));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= ad;
    wbDatW <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, m, input string nm);
    nq.push_back('{e, m, nm});
    wb(1'b0, ad, 32'h0);
  endtask : rd
  task automatic op(input sesc_pkg::sesc_op_t o, input logic [31:0] v);
    int i;
    if (o == sesc_pkg::OP_CFG_WRITE) wb(1'b1, sesc_pkg::REG_CFG, v);
    if (o == sesc_pkg::OP_DATA_READ) wb(1'b1, sesc_pkg::REG_ADDR, v);
    // clear done, abort and flag so a stale done cannot end the poll early
    wb(1'b1, sesc_pkg::REG_STATUS, 32'h0000_000e);
    wb(1'b1, sesc_pkg::REG_CTRL, {29'h0, o, 1'b1});
    i = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && i < 60) begin
      rd(sesc_pkg::REG_STATUS, 32'h0, 32'h0, "poll");
      i++;
    end
    cmp("op done", 32'h2, {30'h0, q[1], 1'b0});
  endtask : op
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // queued expectations are compared as read answers arrive
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && nq.size() > 0) begin
      if (nq[0].m != 32'h0) cmp(nq[0].nm, nq[0].e & nq[0].m, wbDatR & nq[0].m);
      void'(nq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {wbCyc, wbStb, wbWe, scrubReq} = 4'h0;
    wbSel = 4'hf;
    wbAdr = 8'h0;
    wbDatW = 32'h0;
    errInj = 2'h0;
    lf = 16'h809e;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(sesc_pkg::REG_CFG, {19'h0, sesc_pkg::CFG_RESET}, 32'h1fff, "cfg reset");
    rd(sesc_pkg::REG_STATUS, 32'h0, 32'h1ff, "status reset");
    rd(8'h1c, 32'h0, '1, "unmapped");
    $display("test reset done");
    op(sesc_pkg::OP_CFG_WRITE, 32'h00a7);
    op(sesc_pkg::OP_CFG_READ, 32'h0);
    rd(sesc_pkg::REG_RESULT, 32'h00a7, 32'h1fff, "cfg readback");
    op(sesc_pkg::OP_CNT_READ, 32'h0);
    rd(sesc_pkg::REG_RESULT, 32'h7ffff, 32'h7ffff, "counter preset");
    rd(sesc_pkg::REG_STATUS, 32'h80, 32'h180, "cfg valid");
    $display("test config done");
    errInj <= 2'h2;
    scrubReq <= 1'b1;
    @(posedge clk);
    scrubReq <= 1'b0;
    op(sesc_pkg::OP_CNT_READ, 32'h0);
    rd(sesc_pkg::REG_RESULT, 32'h0, 32'h7ffff, "scrub counter");
    rd(sesc_pkg::REG_STATUS, 32'h40, 32'h40, "scrub error");
    $display("test scrub done");
    for (int c = 0; c < 3; c++) begin
      for (int k = 1; k < 3; k++) begin
        cv = (c == 0) ? 13'h00a7 : (c == 1) ? 13'h10a7 : 13'h01a7;
        op(sesc_pkg::OP_CFG_WRITE, {19'h0, cv});
        wb(1'b1, sesc_pkg::REG_STATUS, 32'h4e);
        errInj <= k[1:0];
        lf = lfsr(lf);
        a = {lf[2:0], lf};
        f = (c == 2) ? 1'b0 : (c == 1) ? k[0] : k[1];
        op(sesc_pkg::OP_DATA_READ, {13'h0, a});
        rd(sesc_pkg::REG_RESULT, {13'h0, a} ^ 32'h5a5a0000, '1, "data");
        rd(sesc_pkg::REG_STATUS, {23'h0, cv[12], 4'h0, f, 3'h0}, 32'h108, "flag");
      end
    end
    cmp("dq idle", 32'h0, dqOut);
    cmp("write and dq enable", 32'h2, {30'h0, weN, dqOe});
    $display("test classes done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
